// >>> mvop_pkg.sv
// Package with descriptor layout, opcodes, status codes and register map
package mvop_pkg;
  // Opcodes
  localparam logic [7:0] OP_MOVE    = 8'h03;
  localparam logic [7:0] OP_FILL    = 8'h04;
  localparam logic [7:0] OP_COMPARE = 8'h05;
  // Completion status codes
  localparam logic [7:0] ST_NONE     = 8'h00;
  localparam logic [7:0] ST_SUCCESS  = 8'h01;
  localparam logic [7:0] ST_FALSE_PR = 8'h02;
  localparam logic [7:0] ST_FAULT    = 8'h03;
  localparam logic [7:0] ST_OVERLAP  = 8'h04;
  localparam logic [7:0] ST_BAD_OP   = 8'h10;
  // Flag bit positions within the descriptor flags field
  localparam int FLG_CRAV  = 2;
  localparam int FLG_RCR   = 3;
  localparam int FLG_CHECK = 7;
  // Register byte offsets (APB)
  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_STAT   = 8'h04;
  localparam logic [7:0] R_DESC   = 8'h40;
  localparam logic [7:0] R_CREC   = 8'h80;
  localparam int         DESC_W   = 16;
  localparam int         CREC_W   = 4;
  // Control fields
  localparam int CTRL_START   = 0;
  localparam int CTRL_OVLP    = 1;
  localparam int CTRL_FLT_EN  = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  // Memory model words kept locally
  localparam int MEM_AW = 8;
endpackage

// >>> mem_if.sv
// Byte-wide local memory port bundle
`timescale 1ns/100ps
interface mem_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> byte_mem.sv
// Byte memory standing in for host memory, registered read data
`timescale 1ns/100ps
module byte_mem
  import mvop_pkg::*;
(
  input  wire logic clk,
  input  wire logic ce,
  mem_if.mem        port
);
  logic [7:0] store [0:(1<<MEM_AW)-1];
  // Write and registered read
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (port.we)
        store[port.waddr] <= port.wdata;
      port.rdata <= store[port.raddr];
    end
  end
endmodule

// >>> mvop_engine.sv
// Copy, fill and compare execution engine with APB register access
//
// Operation
// - copy reads source, writes destination, moving exactly byte-count bytes
// - copy accepts any byte alignment of addresses and count
// - overlap supported: reverse direction when destination starts above source, so destination receives original source
// - overlap unsupported: overlapping copy ends with an error status
// - faulted copy reports direction in result, 0 forward, 1 reversed
// - direction is chosen afresh for each descriptor
// - fill writes the 8-byte pattern repeatedly to destination
// - fill writes exactly byte count, ending partway through pattern
// - fill accepts any destination alignment and count
// - faulted fill reports bytes written before fault
// - compare walks two regions over byte count, any alignment
// - compare result 0 when identical, 1 when different
// - difference reports offset of first differing byte in progress count
// - faulted compare reports result 0; a difference before the fault byte wins over fault, at the fault byte the fault wins
// - check flag picks success or false-predicate from result versus expected
// - only bit 0 of expected outcome counts
// - false-predicate status is exposed as a predicate level for fencing
`timescale 1ns/100ps
module mvop_engine
  import mvop_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             pred_false
);
  import mvop_pkg::*;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rs1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_READ  = 3'b011,
    S_WAIT  = 3'b010,
    S_ACT   = 3'b110,
    S_DONE  = 3'b111
  } state_t;
  state_t      state_q;
  logic [31:0] ctrl_q;
  logic [31:0] desc_q [0:DESC_W-1];
  logic [31:0] crec_q [0:CREC_W-1];
  logic [31:0] fault_at_q;
  logic [31:0] done_q;
  logic        rev_q;
  logic        rd2_q;
  logic [7:0]  b1_q;
  logic        diff_q;
  logic        pred_q;

  // Descriptor fields, 64-byte layout
  logic [7:0]  opcode;
  logic [23:0] flags;
  logic [31:0] src_a;
  logic [31:0] dst_a;
  logic [31:0] xfer_n;
  logic [63:0] pattern;
  logic        exp_bit;
  assign opcode  = desc_q[1][31:24];
  assign flags   = desc_q[1][23:0];
  assign src_a   = desc_q[4];
  assign dst_a   = desc_q[6];
  assign xfer_n  = desc_q[8];
  assign pattern = {desc_q[5], desc_q[4]};
  assign exp_bit = desc_q[10][0];

  logic wr_en;
  logic rd_en;
  logic wr_map;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !pwrite;
  assign wr_map = (paddr == R_CTRL) || (paddr == R_STAT)
               || (paddr >= R_DESC && paddr < R_DESC + 8'(DESC_W*4));
  assign pready = 1'b1;
  assign busy   = (state_q != S_IDLE);
  assign pred_false = pred_q;

  // APB read data and error answer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce && psel && !penable)
    begin
      pslverr <= 1'b0; // Decided in setup, stands at access edge
      if (!rd_en)
        pslverr <= !wr_map;
      else if (paddr == R_CTRL)
        prdata <= ctrl_q;
      else if (paddr == R_STAT)
        prdata <= {30'h0000_0000, pred_q, busy};
      else if (paddr >= R_DESC && paddr < R_DESC + 8'(DESC_W*4))
        prdata <= desc_q[4'(paddr[5:2])];
      else if (paddr >= R_CREC && paddr < R_CREC + 8'(CREC_W*4))
        prdata <= crec_q[2'(paddr[3:2])];
      else
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end

  // Control register; start bit clears itself when taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= CTRL_RST;
    else if (ce)
    begin
      if (wr_en && paddr == R_CTRL)
        ctrl_q <= pwdata;
      else if (state_q == S_SETUP)
        ctrl_q[CTRL_START] <= 1'b0;
    end
  end

  // Fault position register (a page fault is modelled at this byte index)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fault_at_q <= 32'hffff_ffff;
    else if (ce && wr_en && paddr == R_STAT)
      fault_at_q <= pwdata;
  end

  // Descriptor words written by software, one generate per word
  genvar gi;
  generate
    for (gi = 0; gi < DESC_W; gi++)
    begin : g_desc
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          desc_q[gi] <= 32'h0000_0000;
        else if (ce && wr_en && state_q == S_IDLE && paddr == R_DESC + 8'(gi*4))
          desc_q[gi] <= pwdata;
      end
    end
  endgenerate

  // ****************************************
  // Engine
  // ****************************************
  mem_if mp ();
  byte_mem u_mem (.clk(clk), .ce(ce), .port(mp));

  logic        overlap;
  logic        is_move;
  logic        is_cmp;
  logic [31:0] idx;
  logic [31:0] sa;
  logic [31:0] da;
  logic        hit_fault;
  logic        fin;
  assign is_move = (opcode == OP_MOVE);
  assign is_cmp  = (opcode == OP_COMPARE);
  // Regions overlap when each starts before the other ends
  assign overlap = (xfer_n != 32'h0) && (src_a < dst_a + xfer_n) && (dst_a < src_a + xfer_n);
  // Reverse index walks from the end backward
  assign idx = rev_q ? (xfer_n - 32'h1 - done_q) : done_q;
  assign sa  = src_a + idx;
  assign da  = (is_cmp ? desc_q[6] : dst_a) + idx;
  assign hit_fault = ctrl_q[CTRL_FLT_EN] && (done_q == fault_at_q);
  assign fin = (done_q == xfer_n);

  // Memory port requests: read source (compare: second region) in SETUP, write in ACT
  always_comb
  begin
    mp.raddr = 8'h00;
    mp.we    = 1'b0;
    mp.waddr = da[7:0];
    mp.wdata = 8'h00;
    case (state_q)
      S_SETUP: mp.raddr = is_cmp ? da[7:0] : sa[7:0];
      S_READ, S_WAIT: mp.raddr = sa[7:0]; // Source held so ACT sees its byte
      S_ACT:
      begin
        mp.raddr = sa[7:0];
        if (!is_cmp && !hit_fault && !fin)
        begin
          mp.we    = 1'b1;
          // Pattern byte picked by running count, so a tail stops mid pattern
          mp.wdata = is_move ? mp.rdata : pattern[8*done_q[2:0] +: 8];
        end
      end
      default: mp.raddr = 8'h00;
    endcase
  end

  // Main sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      done_q  <= 32'h0;
      rev_q   <= 1'b0;
      rd2_q   <= 1'b0;
      b1_q    <= 8'h00;
      diff_q  <= 1'b0;
    end
    else if (ce)
    begin
      case (state_q)
        S_IDLE:
        begin
          if (ctrl_q[CTRL_START])
          begin
            state_q <= S_SETUP;
            done_q  <= 32'h0;
            diff_q  <= 1'b0;
            // Reverse only when destination starts inside the source
            rev_q   <= is_move && ctrl_q[CTRL_OVLP] && overlap && (dst_a > src_a);
          end
        end
        S_SETUP:
        begin
          if (is_move && overlap && !ctrl_q[CTRL_OVLP])
            state_q <= S_DONE;
          else if (!is_move && !is_cmp && opcode != OP_FILL)
            state_q <= S_DONE;
          else
            state_q <= is_cmp ? S_READ : S_WAIT;
        end
        S_READ:
        begin
          b1_q    <= mp.rdata; // Second region byte, read in SETUP
          state_q <= S_WAIT;
        end
        S_WAIT:
          state_q <= S_ACT;
        S_ACT:
        begin
          if (fin || hit_fault)
            state_q <= S_DONE;
          else if (is_cmp && b1_q != mp.rdata)
          begin
            diff_q  <= 1'b1;
            state_q <= S_DONE;
          end
          else
          begin
            done_q  <= done_q + 32'h1;
            state_q <= S_SETUP;
          end
        end
        S_DONE:
          state_q <= S_IDLE;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // Completion record and predicate
  logic [7:0] status_d;
  logic [7:0] result_d;
  always_comb
  begin
    status_d = ST_SUCCESS;
    result_d = 8'h00;
    if (is_move && overlap && !ctrl_q[CTRL_OVLP])
      status_d = ST_OVERLAP;
    else if (!is_move && !is_cmp && opcode != OP_FILL)
      status_d = ST_BAD_OP;
    else if (is_cmp && diff_q)
    begin
      result_d = 8'h01;
      if (flags[FLG_CHECK] && !exp_bit)
        status_d = ST_FALSE_PR;
    end
    else if (!fin && hit_fault)
    begin
      status_d = ST_FAULT;
      // Direction only on copy; compare fault reports 0
      result_d = {7'h00, is_move && rev_q && ctrl_q[CTRL_OVLP]};
    end
    else if (is_cmp && flags[FLG_CHECK] && exp_bit)
      status_d = ST_FALSE_PR;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crec_q[0] <= 32'h0;
      crec_q[1] <= 32'h0;
      crec_q[2] <= 32'h0;
      crec_q[3] <= 32'h0;
      pred_q    <= 1'b0;
    end
    else if (ce && state_q == S_DONE)
    begin
      crec_q[0] <= {16'h0000, result_d, status_d};
      crec_q[1] <= done_q;
      crec_q[2] <= (status_d == ST_FAULT) ? (rev_q ? sa : (is_move ? da : (is_cmp ? sa : da)))
                                         : 32'h0;
      crec_q[3] <= 32'h0;
      pred_q    <= (status_d == ST_FALSE_PR);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_fill_count: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == S_ACT && mp.we) |-> (done_q < xfer_n))
    else $error("write past byte count");
  a_no_ovlp_err: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && state_q == S_SETUP && is_move && overlap && !ctrl_q[CTRL_OVLP]) |=> ##1
    (crec_q[0][7:0] == ST_OVERLAP))
    else $error("overlap not flagged");
  a_res_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (is_move && !ctrl_q[CTRL_OVLP] && state_q == S_IDLE && $past(state_q) == S_DONE)
    |-> crec_q[0][15:8] == 8'h00)
    else $error("copy result not zero");
  a_pred_tie: assert property (@(posedge clk) disable iff (!rst_n)
    pred_false == (crec_q[0][7:0] == ST_FALSE_PR))
    else $error("predicate mismatch");
  a_diff_result: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && state_q == S_DONE && is_cmp && diff_q) |=> (crec_q[0][15:8] == 8'h01))
    else $error("difference not reported");
  a_cmp_fault_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && state_q == S_DONE && is_cmp && status_d == ST_FAULT) |=> crec_q[0][15:8] == 8'h00)
    else $error("faulted compare result not zero");
endmodule

// >>> soft_host.sv
// Software-side partner: APB master that builds descriptors and starts the engine
`timescale 1ns/100ps
module soft_host
  import mvop_pkg::*;
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rd_q;
  logic        err_q;

  // Idle bus from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One transfer: setup, access held until pready, release after it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd_q    = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Descriptor words, fault index, start, then poll until idle
  task automatic run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] sz, input logic [63:0] pat, input logic [7:0] flg,
                     input logic [7:0] ex, input logic [7:0] ctl, input logic [7:0] fi);
    xfer(1'b1, R_DESC + 8'h04, {op, 16'h0000, flg | 8'h0c});
    xfer(1'b1, R_DESC + 8'h10, (op == OP_FILL) ? pat[31:0] : {24'h00_0000, a});
    xfer(1'b1, R_DESC + 8'h14, (op == OP_FILL) ? pat[63:32] : 32'h0000_0000);
    xfer(1'b1, R_DESC + 8'h18, {24'h00_0000, b});
    xfer(1'b1, R_DESC + 8'h20, {24'h00_0000, sz});
    xfer(1'b1, R_DESC + 8'h28, {24'h00_0000, ex});
    xfer(1'b1, R_STAT, {24'h00_0000, fi});
    xfer(1'b1, R_CTRL, {24'h00_0000, ctl});
    rd_q = 32'h0000_0001;
    while (rd_q[0] !== 1'b0)
      xfer(1'b0, R_STAT, 32'h0000_0000);
  endtask
endmodule

// >>> memory_move_fill_compare_ops_tb.sv
// Self-checking bench for the copy, fill and compare engine
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    comparisons++; \
    if ((gt) !== (ex)) \
    begin \
      $display("BAD %s exp %h got %h", nm, ex, gt); \
      bad_count++; \
    end \
  end
module memory_move_fill_compare_ops_tb;
  import mvop_pkg::*;
  // Short aliases keep the case table narrow
  localparam logic [7:0] FL = OP_FILL;
  localparam logic [7:0] MV = OP_MOVE;
  localparam logic [7:0] CP = OP_COMPARE;
  localparam logic [7:0] OK = ST_SUCCESS;
  localparam logic [7:0] FP = ST_FALSE_PR;
  localparam logic [7:0] FT = ST_FAULT;
  localparam logic [63:0] PAT = 64'h8877_6655_4433_2211;
  typedef struct packed {
    logic [7:0] op, a, b, sz, flg, ex, ctl, fi;
    logic       pq;
    logic [7:0] st, res, prg;
  } row_t;
  // op a b size flags expected ctrl fault-index inverted-pattern status result progress
  localparam row_t ROWS [27] = '{
    '{FL,8'h00,8'h00,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{FL,8'h00,8'h10,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{FL,8'h00,8'h40,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'h10,8'h40,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{FL,8'h00,8'h43,8'h05,8'h00,8'h00,8'h03,8'h00,1'b1,OK,8'h00,8'h00},
    '{CP,8'h10,8'h40,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h01,8'h03},
    '{CP,8'h18,8'h48,8'h08,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'h10,8'h40,8'h10,8'h80,8'hfe,8'h03,8'h00,1'b0,FP,8'h01,8'h03},
    '{CP,8'h10,8'h40,8'h10,8'h80,8'h01,8'h03,8'h00,1'b0,OK,8'h01,8'h03},
    '{CP,8'h18,8'h48,8'h08,8'h80,8'hff,8'h03,8'h00,1'b0,FP,8'h00,8'h00},
    '{MV,8'h10,8'h13,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{FL,8'h00,8'h80,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'h13,8'h80,8'h10,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{MV,8'h20,8'h21,8'h04,8'h00,8'h00,8'h01,8'h00,1'b0,ST_OVERLAP,8'h00,8'h00},
    '{MV,8'h80,8'ha1,8'h09,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'ha1,8'h80,8'h09,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{FL,8'h00,8'h00,8'h0a,8'h00,8'h00,8'h07,8'h05,1'b1,FT,8'h00,8'h05},
    '{FL,8'h00,8'hc0,8'h10,8'h00,8'h00,8'h03,8'h00,1'b1,OK,8'h00,8'h00},
    '{MV,8'h00,8'hc0,8'h0a,8'h00,8'h00,8'h07,8'h05,1'b0,FT,8'h00,8'h05},
    '{CP,8'h00,8'hc0,8'h0a,8'h00,8'h00,8'h07,8'h05,1'b0,FT,8'h00,8'h05},
    '{MV,8'h05,8'hc5,8'h05,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'h00,8'hc0,8'h0a,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'h10,8'h40,8'h10,8'h00,8'h00,8'h07,8'h05,1'b0,OK,8'h01,8'h03},
    '{MV,8'h00,8'h04,8'h08,8'h00,8'h00,8'h07,8'h05,1'b0,FT,8'h01,8'h05},
    '{MV,8'h00,8'h04,8'h03,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{CP,8'h00,8'h04,8'h04,8'h00,8'h00,8'h03,8'h00,1'b0,OK,8'h00,8'h00},
    '{8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8'h03,8'h00,1'b0,ST_BAD_OP,8'h00,8'h00}
  };
  logic        clk;
  logic        arst_n;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        pred_false;
  int          bad_count = 0;
  int          comparisons = 0;
  row_t        r;

  soft_host host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
                    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
                    .pslverr(pslverr));
  mvop_engine dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
                     .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                     .pready(pready), .pslverr(pslverr), .busy(busy), .pred_false(pred_false));

  // Verdict and end of run
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever
      #50 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  initial
  begin
    #4000000;
    bad_count++;
    complete_run();
  end

  // Table of cases, then reset and decode checks
  initial
  begin
    arst_n = 1'b0;
    ce     = 1'b1;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      host_u.run(r.op, r.a, r.b, r.sz, r.pq ? ~PAT : PAT, r.flg, r.ex, r.ctl, r.fi);
      host_u.xfer(1'b0, R_CREC, 32'h0000_0000);
      `CHK("status", r.st, host_u.rd_q[7:0])
      `CHK("result", r.res, host_u.rd_q[15:8])
      `CHK("predicate", r.st == FP, pred_false)
      host_u.xfer(1'b0, R_CREC + 8'h04, 32'h0000_0000);
      if (r.res == 8'h01 || r.st == FT)
        `CHK("progress", {24'h00_0000, r.prg}, host_u.rd_q)
    end
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #10;
    `CHK("busy_rst", 1'b0, busy)
    `CHK("pred_rst", 1'b0, pred_false)
    `CHK("rdata_rst", 32'h0000_0000, prdata)
    `CHK("ready", 1'b1, pready)
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    host_u.xfer(1'b0, R_CTRL, 32'h0000_0000);
    `CHK("ctrl_rst", CTRL_RST, host_u.rd_q)
    `CHK("err_ok", 1'b0, host_u.err_q)
    host_u.xfer(1'b0, 8'hf0, 32'h0000_0000);
    `CHK("err_unmapped", 1'b1, host_u.err_q)
    host_u.xfer(1'b1, R_CREC, 32'h0000_0000);
    `CHK("err_wr_ro", 1'b1, host_u.err_q)
    // Write with the enable low must leave control untouched
    ce <= 1'b0;
    host_u.xfer(1'b1, R_CTRL, 32'h0000_0001);
    ce <= 1'b1;
    host_u.xfer(1'b0, R_CTRL, 32'h0000_0000);
    `CHK("ctrl_frozen", CTRL_RST, host_u.rd_q)
    complete_run();
  end
endmodule
